// >>> core/cbb_config_header.sv
`timescale 1ns/1ps
module cbb_config_header
    import cbb_pkg::*;
#(
    parameter int WIN_BITS = WIN_LSB
)
(
    input wire logic clock,
    input wire logic rst,
    // Configuration access port
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ready,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // Extension space hand-off
    output logic ext_sel,
    output logic pm_sel,
    input wire logic [31:0] ext_rdata,
    // Card-side events, one-cycle pulses
    input wire logic card_addr_parity_err,
    input wire logic card_data_parity_err,
    input wire logic card_serr_seen,
    input wire logic card_master_abort,
    input wire logic card_target_abort_rx,
    input wire logic card_target_abort_tx,
    input wire logic card_perr_seen,
    input wire logic card_was_master,
    input wire logic parity_resp_en,
    // Forwarding of type-1 configuration cycles
    input wire logic fwd_req,
    input wire logic [7:0] fwd_bus,
    output logic fwd_done,
    output logic fwd_type0,
    output logic fwd_type1,
    // Memory claim of the socket window
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_done,
    output logic mem_claim,
    output logic mem_legacy,
    output logic [11:0] mem_offset,
    // Register views for the rest of the bridge
    output logic [31:0] socket_window_base,
    output logic [7:0] upstream_bus_number,
    output logic [7:0] card_bus_number,
    output logic [7:0] highest_downstream_bus
);

    // Window must sit on at least a 4-Kbyte boundary
    generate
        if (WIN_BITS < WIN_LSB || WIN_BITS > 31)
        begin : g_bad_win
            $error("WIN_BITS out of range");
        end
    endgenerate

    // Access sequencer states
    typedef enum logic [1:0] {
        CBB_IDLE = 2'b01,
        CBB_ANSWER = 2'b10
    } cbb_state_e;

    // Dword select shared by reads and writes
    function automatic logic dw_hit(input logic [7:0] addr, input logic [7:0] ofs);
        dw_hit = (addr[7:2] == ofs[7:2]);
    endfunction : dw_hit

    // Byte-enable expansion to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : lane_mask

    cbb_state_e state_reg;
    cbb_state_e state_next;
    logic [31:0] sock_reg;
    logic [31:0] sock_next;
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [7:0] up_bus_reg;
    logic [7:0] up_bus_next;
    logic [7:0] card_bus_reg;
    logic [7:0] card_bus_next;
    logic [7:0] high_bus_reg;
    logic [7:0] high_bus_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ack_reg;

    // Request acceptance: one access at a time
    wire take = cfg_req && (state_reg == CBB_IDLE);
    wire wr_take = take && cfg_write;
    wire [31:0] be_mask = lane_mask(cfg_byte_en);

    // Register decode by dword: standard header, plus the PM dwords A0h/A4h
    wire in_ext = cfg_addr[7];
    wire sel_hdr = !in_ext && dw_hit(cfg_addr, HDR_TYPE_OFS);
    wire sel_sock = !in_ext && dw_hit(cfg_addr, SOCK_BASE_OFS);
    wire sel_stat = !in_ext && dw_hit(cfg_addr, CARD_STAT_OFS);
    wire sel_bus = !in_ext && dw_hit(cfg_addr, UP_BUS_OFS);
    wire pm_hit = dw_hit(cfg_addr, PM_DW0_OFS) || dw_hit(cfg_addr, PM_DW1_OFS);

    // Extension space is served outside this block
    assign ext_sel = take && in_ext;
    assign pm_sel = take && in_ext && pm_hit;

    // Access sequencer: request in idle, answer the next cycle
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            CBB_IDLE:
            begin
                if (cfg_req)
                begin
                    state_next = CBB_ANSWER;
                end
            end
            CBB_ANSWER:
            begin
                state_next = CBB_IDLE;
            end
            default:
            begin
                state_next = CBB_IDLE;
            end
        endcase
    end

    assign cfg_ready = (state_reg == CBB_IDLE);

    // Window base: only the upper bits take write data
    wire [31:0] sock_wm = be_mask & SOCK_WR_MASK;
    wire sock_we = wr_take && sel_sock;
    assign sock_next = sock_we ? ((sock_reg & ~sock_wm) | (cfg_wdata & sock_wm)) : sock_reg;

    // Bus numbers: one byte lane each in the same dword
    wire bus_we = wr_take && sel_bus;
    assign up_bus_next = (bus_we && cfg_byte_en[0]) ? cfg_wdata[7:0] : up_bus_reg;
    assign card_bus_next = (bus_we && cfg_byte_en[1]) ? cfg_wdata[15:8] : card_bus_reg;
    assign high_bus_next = (bus_we && cfg_byte_en[2]) ? cfg_wdata[23:16] : high_bus_reg;

    // Card-side event sources
    wire ev_parity = card_addr_parity_err || card_data_parity_err;
    wire ev_serr = card_serr_seen;
    wire ev_mabort = card_master_abort;
    wire ev_tabt_rx = card_target_abort_rx;
    wire ev_tabt_tx = card_target_abort_tx;
    wire ev_dpar = card_perr_seen && card_was_master && parity_resp_en;

    // Gather the events into their flag positions
    logic [15:0] flag_set;
    always_comb
    begin
        flag_set = '0;
        flag_set[ST_PARITY_BIT] = ev_parity;
        flag_set[ST_SYSERR_BIT] = ev_serr;
        flag_set[ST_MABORT_BIT] = ev_mabort;
        flag_set[ST_TABT_RX_BIT] = ev_tabt_rx;
        flag_set[ST_TABT_TX_BIT] = ev_tabt_tx;
        flag_set[ST_DPAR_BIT] = ev_dpar;
    end

    // Write-one-to-clear on the upper half of the status dword
    wire stat_we = wr_take && sel_stat;
    wire [15:0] stat_lanes = be_mask[31:16];
    wire [15:0] flag_clr = stat_we ? (cfg_wdata[31:16] & stat_lanes & STAT_RC_MASK) : 16'h0000;

    // A new event outranks a clear in the same cycle
    assign flags_next = ((flags_reg & ~flag_clr) | flag_set) & STAT_RC_MASK;

    // Status as read: flags plus the hardwired timing field
    wire [15:0] stat_rd = flags_reg | STAT_FIXED;

    // Byte images of the header dwords, fixed bytes with status and bus numbers
    wire [31:0] hdr_word = {SELF_TEST_VAL, HDR_TYPE_VAL, 16'h0000};
    wire [31:0] cap_word = {stat_rd, 8'h00, CAP_PTR_VAL};
    wire [31:0] bus_word = {8'h00, high_bus_reg, card_bus_reg, up_bus_reg};

    // Read selection; unmapped header dwords read zero
    always_comb
    begin
        rdata_next = rdata_reg;
        if (take && !cfg_write)
        begin
            if (in_ext)
            begin
                rdata_next = ext_rdata;
            end
            else if (sel_hdr)
            begin
                rdata_next = hdr_word;
            end
            else if (sel_sock)
            begin
                rdata_next = sock_reg;
            end
            else if (sel_stat)
            begin
                rdata_next = cap_word;
            end
            else if (sel_bus)
            begin
                rdata_next = bus_word;
            end
            else
            begin
                rdata_next = 32'h0000_0000;
            end
        end
        else if (take)
        begin
            rdata_next = 32'h0000_0000;
        end
    end

    // Access sequencer state
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= CBB_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Answer registers: one-cycle acknowledge and the read word
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= take;
            rdata_reg <= rdata_next;
        end
    end

    // Socket window base, low bits never loaded
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sock_reg <= SOCK_RESET;
        end
        else
        begin
            sock_reg <= sock_next;
        end
    end

    // Upstream bus number
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            up_bus_reg <= BUS_RESET;
        end
        else
        begin
            up_bus_reg <= up_bus_next;
        end
    end

    // Card-side bus number
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            card_bus_reg <= BUS_RESET;
        end
        else
        begin
            card_bus_reg <= card_bus_next;
        end
    end

    // Highest bus number below the card side
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            high_bus_reg <= BUS_RESET;
        end
        else
        begin
            high_bus_reg <= high_bus_next;
        end
    end

    // Sticky card-side flags
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            flags_reg <= STAT_RESET & STAT_RC_MASK;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    assign cfg_ack = ack_reg;
    assign cfg_rdata = rdata_reg;
    assign socket_window_base = sock_reg;
    assign upstream_bus_number = up_bus_reg;
    assign card_bus_number = card_bus_reg;
    assign highest_downstream_bus = high_bus_reg;

    // Error pin toward the card is input only; nothing drives it here

    // Forwarding and window claim decisions
    cbb_route_decode #(
        .WIN_BITS(WIN_BITS)
    ) cbb_route_decode_inst (
        .clock(clock),
        .rst(rst),
        .up_bus(up_bus_reg),
        .card_bus(card_bus_reg),
        .high_bus(high_bus_reg),
        .win_base(sock_reg),
        .fwd_req(fwd_req),
        .fwd_bus(fwd_bus),
        .mem_req(mem_req),
        .mem_addr(mem_addr),
        .fwd_done(fwd_done),
        .fwd_type0(fwd_type0),
        .fwd_type1(fwd_type1),
        .mem_done(mem_done),
        .mem_claim(mem_claim),
        .mem_legacy(mem_legacy),
        .mem_offset(mem_offset)
    );

endmodule : cbb_config_header

// >>> core/cbb_route_decode.sv
`timescale 1ns/1ps
module cbb_route_decode
    import cbb_pkg::*;
#(
    parameter int WIN_BITS = WIN_LSB
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] up_bus,
    input wire logic [7:0] card_bus,
    input wire logic [7:0] high_bus,
    input wire logic [31:0] win_base,
    input wire logic fwd_req,
    input wire logic [7:0] fwd_bus,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic fwd_done,
    output logic fwd_type0,
    output logic fwd_type1,
    output logic mem_done,
    output logic mem_claim,
    output logic mem_legacy,
    output logic [11:0] mem_offset
);
    // Bus-number comparisons for a type-1 cycle from the host side
    wire is_own = (fwd_bus == up_bus);
    wire to_type0 = !is_own && (fwd_bus == card_bus);
    wire to_type1 = !is_own && (fwd_bus > card_bus) && (fwd_bus <= high_bus);
    // Window hit: upper address bits match a nonzero programmed base
    wire base_set = (win_base[31:WIN_BITS] != '0);
    wire win_hit = base_set && (mem_addr[31:WIN_BITS] == win_base[31:WIN_BITS]);
    wire legacy = (mem_addr[11:0] >= LEGACY_REGS_OFS);

    // Decisions are registered and answered the cycle after the request
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            fwd_done <= 1'b0;
            fwd_type0 <= 1'b0;
            fwd_type1 <= 1'b0;
            mem_done <= 1'b0;
            mem_claim <= 1'b0;
            mem_legacy <= 1'b0;
            mem_offset <= SOCKET_REGS_OFS;
        end
        else
        begin
            fwd_done <= fwd_req;
            fwd_type0 <= fwd_req && to_type0;
            fwd_type1 <= fwd_req && to_type1;
            mem_done <= mem_req;
            mem_claim <= mem_req && win_hit;
            mem_legacy <= mem_req && win_hit && legacy;
            mem_offset <= mem_addr[11:0];
        end
    end
endmodule : cbb_route_decode

// >>> inc/cbb_pkg.sv
// How it works
// - Header type byte reads 02h, read-only.
// - Offsets 00h-7Fh standard, 80h-FFh extension.
// - Self-test byte reads 00h, read-only.
// - Window base bits 31-12 writable, rest zero.
// - All-ones write reads back FFFF F000h.
// - Socket registers at 000h, legacy at 800h.
// - Capability pointer reads A0h; PM at A0h/A4h.
// - Status flags clear on write-one; reset 0200h.
// - Bit 15 set on card parity error.
// - Bit 14 set on card system error.
// - Bit 13 set on received master abort.
// - Bit 12 set on received target abort.
// - Bit 11 set on signaled target abort.
// - Bits 10-9 hardwired to 01b.
// - Bit 8 needs error, mastership, response enable.
// - Bits 7, 6, 5 read zero.
// - Bits 4-0 reserved, read zero.
// - Bus numbers writable, reset 00h, steer forwarding.
package cbb_pkg;
    localparam logic [7:0] HDR_TYPE_OFS = 8'h0E;
    localparam logic [7:0] SELF_TEST_OFS = 8'h0F;
    localparam logic [7:0] SOCK_BASE_OFS = 8'h10;
    localparam logic [7:0] CAP_PTR_OFS = 8'h14;
    localparam logic [7:0] CARD_STAT_OFS = 8'h16;
    localparam logic [7:0] UP_BUS_OFS = 8'h18;
    localparam logic [7:0] CARD_BUS_OFS = 8'h19;
    localparam logic [7:0] HIGH_BUS_OFS = 8'h1A;
    localparam logic [7:0] EXT_FIRST_OFS = 8'h80;
    localparam logic [7:0] PM_DW0_OFS = 8'hA0;
    localparam logic [7:0] PM_DW1_OFS = 8'hA4;
    localparam logic [7:0] HDR_TYPE_VAL = 8'h02;
    localparam logic [7:0] SELF_TEST_VAL = 8'h00;
    localparam logic [7:0] CAP_PTR_VAL = 8'hA0;
    localparam logic [31:0] SOCK_RESET = 32'h0000_0000;
    localparam logic [31:0] SOCK_WR_MASK = 32'hFFFF_F000;
    localparam logic [7:0] BUS_RESET = 8'h00;
    localparam logic [15:0] STAT_RESET = 16'h0200;
    localparam logic [15:0] STAT_RC_MASK = 16'hF900;
    localparam logic [15:0] STAT_FIXED = 16'h0200;
    localparam int ST_PARITY_BIT = 15;
    localparam int ST_SYSERR_BIT = 14;
    localparam int ST_MABORT_BIT = 13;
    localparam int ST_TABT_RX_BIT = 12;
    localparam int ST_TABT_TX_BIT = 11;
    localparam int ST_DPAR_BIT = 8;
    localparam int WIN_LSB = 12;
    localparam int LEGACY_BIT = 11;
    localparam logic [11:0] SOCKET_REGS_OFS = 12'h000;
    localparam logic [11:0] LEGACY_REGS_OFS = 12'h800;
endpackage : cbb_pkg

// >>> testbench/cbb_header_asserts.sv
`timescale 1ns/1ps
module cbb_header_asserts
    import cbb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_ready,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic ext_sel,
    input wire logic pm_sel,
    input wire logic fwd_req,
    input wire logic fwd_done,
    input wire logic fwd_type0,
    input wire logic fwd_type1,
    input wire logic mem_req,
    input wire logic mem_done
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // Taken reads of the fixed header dwords
    wire take = cfg_req && cfg_ready;
    wire rd_take = take && !cfg_write;
    wire rd_hdr = rd_take && cfg_addr[7:2] == 6'h03;
    wire rd_base = rd_take && cfg_addr[7:2] == 6'h04;
    wire rd_cap = rd_take && cfg_addr[7:2] == 6'h05;
    wire rd_bus = rd_take && cfg_addr[7:2] == 6'h06;
    a_header_bytes: assert property (rd_hdr |=> cfg_ack && cfg_rdata[31:16] == 16'h0002)
        else $error("header type or self-test byte wrong");
    a_base_low_zero: assert property (rd_base |=> cfg_ack && cfg_rdata[11:0] == 12'h000)
        else $error("window base low bits not zero");
    a_cap_pointer: assert property (rd_cap |=> cfg_rdata[15:0] == 16'h00A0)
        else $error("capability pointer wrong");
    a_status_fixed: assert property (rd_cap |-> ##1 cfg_rdata[26:25] == 2'b01 && cfg_rdata[23:16] == 8'h00)
        else $error("status fixed bits wrong");
    a_bus_top_zero: assert property (rd_bus |=> cfg_rdata[31:24] == 8'h00)
        else $error("bus number dword top byte not zero");
    a_write_ack: assert property (take && cfg_write |=> cfg_ack && cfg_rdata == 32'h0 ##1 !cfg_ack)
        else $error("write answer wrong");
    a_ext_select: assert property (1'b1 |-> ext_sel == (take && cfg_addr[7]))
        else $error("extension select wrong");
    a_pm_select: assert property (pm_sel |-> ext_sel && cfg_addr[7:3] == 5'h14)
        else $error("power management select wrong");
    a_fwd_answer: assert property (fwd_req |=> fwd_done && !(fwd_type0 && fwd_type1))
        else $error("forward answer wrong");
    a_mem_answer: assert property (mem_req |-> ##1 mem_done)
        else $error("memory answer missing");
endmodule : cbb_header_asserts

bind cbb_config_header cbb_header_asserts cbb_header_asserts_inst (.clock, .rst, .cfg_req, .cfg_write, .cfg_addr,
    .cfg_ready, .cfg_ack, .cfg_rdata, .ext_sel, .pm_sel, .fwd_req, .fwd_done, .fwd_type0, .fwd_type1, .mem_req,
    .mem_done);

// >>> testbench/cbb_host_model.sv
`timescale 1ns/1ps
module cbb_host_model
    import cbb_pkg::*;
(
    input wire logic clock,
    output logic cfg_req,
    output logic cfg_write,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata,
    input wire logic cfg_ready,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    // Idle bus at time zero
    initial {cfg_req, cfg_write, cfg_addr, cfg_byte_en, cfg_wdata} = '0;
    // One configuration cycle; released qualifiers are scrambled
    task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
        output logic [31:0] q, output bit ok);
        int n;
        n = 0;
        // Let an edge pass so a new request never follows a release in the same step
        @(posedge clock);
        #2;
        cfg_req = 1'b1;
        cfg_write = wr;
        cfg_addr = a;
        cfg_byte_en = be;
        cfg_wdata = d;
        while (!cfg_ready && n < 8)
        begin
            @(posedge clock);
            #2;
            n++;
        end
        @(posedge clock);
        #2;
        cfg_req = 1'b0;
        cfg_write = ~wr;
        cfg_addr = ~a;
        cfg_byte_en = ~be;
        cfg_wdata = ~d;
        ok = cfg_ack === 1'b1 && n < 8;
        q = cfg_rdata;
    endtask : access
endmodule : cbb_host_model

// >>> testbench/test_cbb_config_header.sv
`timescale 1ns/1ps
module test_cbb_config_header;
    import cbb_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [5:0] ev = 6'h00;
    logic [2:0] pv = 3'h0;
    logic fwd_req = 1'b0;
    logic mem_req = 1'b0;
    logic [7:0] fwd_bus = 8'h00;
    logic [31:0] mem_addr = 32'h0;
    logic [31:0] ext_rdata = 32'h0;
    logic cfg_req, cfg_write, cfg_ready, cfg_ack, fwd_done, fwd_type0, fwd_type1, mem_done, mem_claim, mem_legacy;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_byte_en;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [11:0] mem_offset;
    logic [31:0] sock_view;
    logic [7:0] up_view, card_view, high_view;
    int failures = 0;
    int compares = 0;
    int bits[6] = '{15, 15, 14, 13, 12, 11};
    cbb_config_header cbb_config_header_inst (.clock, .rst, .cfg_req, .cfg_write, .cfg_addr, .cfg_byte_en, .cfg_wdata,
        .cfg_ready, .cfg_ack, .cfg_rdata, .ext_sel(), .pm_sel(), .ext_rdata, .card_addr_parity_err(ev[0]),
        .card_data_parity_err(ev[1]), .card_serr_seen(ev[2]), .card_master_abort(ev[3]),
        .card_target_abort_rx(ev[4]), .card_target_abort_tx(ev[5]), .card_perr_seen(pv[0]),
        .card_was_master(pv[1]), .parity_resp_en(pv[2]), .fwd_req, .fwd_bus, .fwd_done, .fwd_type0, .fwd_type1,
        .mem_req, .mem_addr, .mem_done, .mem_claim, .mem_legacy, .mem_offset, .socket_window_base(sock_view),
        .upstream_bus_number(up_view), .card_bus_number(card_view), .highest_downstream_bus(high_view));
    cbb_host_model cbb_host_model_inst (.clock, .cfg_req, .cfg_write, .cfg_addr, .cfg_byte_en, .cfg_wdata,
        .cfg_ready, .cfg_ack, .cfg_rdata);
    // Clock generator
    always #25 clock = ~clock;
    task automatic complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic tick;
        @(posedge clock);
        #2;
    endtask : tick
    // Access through the host; a lost answer ends the run
    task automatic cyc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
        input logic [31:0] exp);
        logic [31:0] q;
        bit ok;
        cbb_host_model_inst.access(w, a, be, d, q, ok);
        if (!ok)
        begin
            failures++;
            complete_run();
        end
        check(q, exp);
    endtask : cyc
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        cyc(1'b0, a, 4'hF, 32'h0, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        cyc(1'b1, a, be, d, 32'h0);
    endtask : wr
    // Request held high across calls, so back-to-back requests are made
    task automatic fwd(input logic [7:0] b, input logic [2:0] e);
        fwd_req = 1'b1;
        fwd_bus = b;
        tick();
        check({29'h0, fwd_done, fwd_type0, fwd_type1}, {29'h0, e});
    endtask : fwd
    task automatic mem(input logic [31:0] a, input logic [14:0] e);
        mem_req = 1'b1;
        mem_addr = a;
        tick();
        check({17'h0, mem_done, mem_claim, mem_legacy, mem_offset}, {17'h0, e});
    endtask : mem
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clock);
        #2;
        rst = 1'b0;
        tick();
        rd(8'h0C, 32'h0002_0000);
        rd(8'h10, 32'h0);
        rd(8'h14, 32'h0200_00A0);
        rd(8'h18, 32'h0);
        wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0002_0000);
        wr(8'h14, 4'h1, 32'h0000_005F);
        rd(8'h14, 32'h0200_00A0);
        $display("test read_only done");
        wr(8'h10, 4'hF, 32'hFFFF_FFFF);
        rd(8'h10, 32'hFFFF_F000);
        wr(8'h10, 4'hF, 32'h1234_5ABC);
        wr(8'h10, 4'h8, 32'hAB00_0000);
        rd(8'h10, 32'hAB34_5000);
        check(sock_view, 32'hAB34_5000);
        $display("test window_base done");
        wr(8'h18, 4'h7, 32'hFF05_0301);
        rd(8'h18, 32'h0005_0301);
        check({8'h00, high_view, card_view, up_view}, 32'h0005_0301);
        fwd(8'h03, 3'b110);
        fwd(8'h04, 3'b101);
        fwd(8'h05, 3'b101);
        fwd(8'h06, 3'b100);
        fwd(8'h02, 3'b100);
        fwd(8'h01, 3'b100);
        fwd_req = 1'b0;
        fwd_bus = 8'hFF;
        mem(32'hAB34_5804, {3'b111, 12'h804});
        mem(32'hAB34_57FC, {3'b110, 12'h7FC});
        mem(32'hAB34_6000, {3'b100, 12'h000});
        mem_req = 1'b0;
        mem_addr = 32'h0;
        $display("test forwarding done");
        for (int i = 0; i < 6; i++)
        begin
            ev = 6'(1 << i);
            tick();
            ev = 6'h00;
            rd(8'h14, {16'h0200 | (16'h0001 << bits[i]), 16'h00A0});
            wr(8'h14, 4'hC, 32'h0000_0000);
            rd(8'h14, {16'h0200 | (16'h0001 << bits[i]), 16'h00A0});
            wr(8'h14, 4'hC, {16'h0001 << bits[i], 16'h0000});
            rd(8'h14, 32'h0200_00A0);
        end
        for (int i = 3; i < 8; i++)
        begin
            pv = 3'(i);
            tick();
            pv = 3'h0;
            rd(8'h14, {(i == 7) ? 16'h0300 : 16'h0200, 16'h00A0});
        end
        wr(8'h14, 4'hC, 32'h0100_0000);
        rd(8'h14, 32'h0200_00A0);
        $display("test status_flags done");
        ext_rdata = 32'h5A5A_0F0F;
        rd(8'hA4, 32'h5A5A_0F0F);
        rd(8'h80, 32'h5A5A_0F0F);
        rd(8'h7C, 32'h0);
        $display("test extension done");
        ev = 6'h01;
        tick();
        ev = 6'h00;
        rst = 1'b1;
        tick();
        rst = 1'b0;
        tick();
        rd(8'h14, 32'h0200_00A0);
        rd(8'h10, 32'h0);
        rd(8'h18, 32'h0);
        check(sock_view | {8'h00, high_view, card_view, up_view}, 32'h0);
        $display("test second_reset done");
        complete_run();
    end
endmodule : test_cbb_config_header
